// file: design/afe_cfg_pkg.sv
// Constants and types for the analog front end configuration register bank
package afe_cfg_pkg;
	// ----------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------
	localparam logic [4:0] IDX_PIN = 5'h0b;
	localparam logic [4:0] IDX_GSW = 5'h0c;
	localparam logic [4:0] IDX_GAMP = 5'h0d;
	localparam logic [4:0] IDX_LED = 5'h0f;
	localparam logic [4:0] IDX_PHO = 5'h10;
	// ----------------------------------------
	// Writable bit masks, reserved bits stay zero
	// ----------------------------------------
	localparam logic [7:0] MASK_PIN = 8'hb7;
	localparam logic [7:0] MASK_GSW = 8'hf0;
	localparam logic [7:0] MASK_GAMP = 8'hff;
	localparam logic [7:0] MASK_LED = 8'h0e;
	localparam logic [7:0] MASK_PHO = 8'h7f;
	localparam logic [7:0] RESET_VAL = 8'h00;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BYP_BIT = 7;
	localparam int SEL_LSB = 4;
	localparam int FN_LSB = 0;
	localparam int RO_BIT = 7;
	localparam int RG_BIT = 6;
	localparam int RI_BIT = 5;
	localparam int REFSW_BIT = 4;
	localparam int R300_BIT = 7;
	localparam int GREF_LSB = 5;
	localparam int GFB_LSB = 3;
	localparam int TDIR_BIT = 2;
	localparam int TEN_BIT = 1;
	localparam int AMP_BIT = 0;
	localparam int LDO_LSB = 1;
	localparam int TCB_LSB = 5;
	localparam int TCA_LSB = 3;
	localparam int PHOTO_REFERENCE_PIN_BIT = 2;
	localparam int PHOTO_GAIN_LEVEL_LSB = 0;
	// ----------------------------------------
	// Pin function codes and bus responses
	// ----------------------------------------
	localparam logic [2:0] FN_HIZ = 3'h0;
	localparam logic [2:0] FN_ERR_OUT = 3'h2;
	localparam logic [2:0] FN_LED_A = 3'h4;
	localparam logic [2:0] FN_LED_B = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [7:0] pin;
		logic [7:0] gsw;
		logic [7:0] gamp;
		logic [7:0] led;
		logic [7:0] pho;
	} regs_t;
endpackage : afe_cfg_pkg

// file: design/afe_config_register_bank.sv
// Configuration register bank with AXI4-Lite slave and decoded analog controls
//
// Summary of operation
// - Bypass bit swaps monitor buffer for switch; else buffer on when select nonzero.
// - Monitor select 0 none, 1 gas amp output, 2 photo output, 3 photodiode.
// - Pin function 0 high impedance; 2 drives high on any unmasked error.
// - Pin function 4: LED A enabled by pin OR dedicated LED A input.
// - Pin function 5: LED B enabled by pin OR dedicated LED B input.
// - Gas switch bits 7,6,5: output resistor, feedback path, input resistor.
// - Gas switch bit 4 moves positive input from sensor pin to reference.
// - Gas amp bit 7 enables the 300 mV reference buffer.
// - Gas reference field bits 6-5 selects 1.25 to 5 mV.
// - Gas feedback field bits 4-3 selects 1100, 300, 500, 800 kOhm.
// - Gas amp bit 2 sets sensor test direction, pull-down or pull-up.
// - Gas amp bit 1 enables sensor test output; bit 0 enables amplifier.
// - LED regulator field bits 3-1 selects 7.5 to 10 V; 6, 7 reserved.
// - LED B temperature coefficient field bits 6-5, four coefficients.
// - LED A temperature coefficient field bits 4-3, same four coefficients.
// - Photo bit 2 ties gain amplifier and pin to 50 mV reference.
// - All five registers reset to zero.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module afe_config_register_bank #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic unmasked_error_i,
	input wire logic gpio_i,
	output logic gpio_o,
	output logic gpio_oe_o,
	input wire logic led_a_enable_input_i,
	input wire logic led_b_enable_input_i,
	output logic led_a_drive_o,
	output logic led_b_drive_o,
	output logic monitor_buffer_on_o,
	output logic monitor_buffer_bypass_o,
	output logic [2:0] monitor_route_o,
	output logic gas_out_resistor_on_o,
	output logic gas_feedback_resistor_on_o,
	output logic gas_in_resistor_on_o,
	output logic gas_ref_switch_on_o,
	output logic ref_300mv_buffer_on_o,
	output logic [1:0] gas_ref_level_o,
	output logic [1:0] gas_feedback_level_o,
	output logic sensor_test_direction_o,
	output logic sensor_test_on_o,
	output logic gas_amplifier_on_o,
	output logic [2:0] led_regulator_level_o,
	output logic [1:0] led_b_temp_coefficient_o,
	output logic [1:0] led_a_temp_coefficient_o,
	output logic photo_reference_select_o,
	output logic [1:0] photo_gain_level_o
);
	generate
		if (ADDR_W < 7 || ADDR_W > 32) begin : g_chk
			$error("ADDR_W must be 7 to 32 to reach every register");
		end
	endgenerate

	// ----------------------------------------
	// Bus handshake state
	// ----------------------------------------
	typedef struct packed {
		logic aw_held;
		logic [ADDR_W-3:0] aw_idx;
		logic w_held;
		logic [7:0] w_data;
		logic w_en;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
	} bus_t;

	bus_t bus;
	bus_t next_bus;
	afe_cfg_pkg::regs_t cfg;
	afe_cfg_pkg::regs_t next_cfg;
	logic wr_do;
	logic [ADDR_W-3:0] wr_idx;
	logic [7:0] wr_data;
	logic wr_en;

	function automatic logic hit(input logic [ADDR_W-3:0] idx);
		hit = idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_PIN) || idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_GSW)
			|| idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_GAMP) || idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_LED)
			|| idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_PHO);
	endfunction : hit

	function automatic logic [7:0] rd(input afe_cfg_pkg::regs_t r, input logic [ADDR_W-3:0] idx);
		rd = 8'h00;
		if (idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_PIN)) rd = r.pin;
		if (idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_GSW)) rd = r.gsw;
		if (idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_GAMP)) rd = r.gamp;
		if (idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_LED)) rd = r.led;
		if (idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_PHO)) rd = r.pho;
	endfunction : rd

	function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] d, input logic [7:0] m);
		upd = (old & ~m) | (d & m);
	endfunction : upd

	always_comb begin
		logic aw_take;
		logic w_take;
		aw_take = s_axi_awvalid_i & bus.awready;
		w_take = s_axi_wvalid_i & bus.wready;
		next_bus = bus;
		if (aw_take) begin
			next_bus.aw_held = 1'b1;
			next_bus.aw_idx = s_axi_awaddr_i[ADDR_W-1:2];
		end
		if (w_take) begin
			next_bus.w_held = 1'b1;
			next_bus.w_data = s_axi_wdata_i[7:0];
			next_bus.w_en = s_axi_wstrb_i[0];
		end
		// Response waits until the previous one is taken
		wr_do = next_bus.aw_held & next_bus.w_held & ~bus.bvalid;
		wr_idx = next_bus.aw_idx;
		wr_data = next_bus.w_data;
		wr_en = next_bus.w_en;
		if (bus.bvalid & s_axi_bready_i) begin
			next_bus.bvalid = 1'b0;
		end
		if (wr_do) begin
			next_bus.aw_held = 1'b0;
			next_bus.w_held = 1'b0;
			next_bus.bvalid = 1'b1;
			next_bus.bresp = hit(wr_idx) ? afe_cfg_pkg::RESP_OKAY : afe_cfg_pkg::RESP_SLVERR;
		end
		next_bus.awready = ~next_bus.aw_held & ~next_bus.bvalid;
		next_bus.wready = ~next_bus.w_held & ~next_bus.bvalid;
		if (bus.rvalid & s_axi_rready_i) begin
			next_bus.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i & bus.arready) begin
			next_bus.rvalid = 1'b1;
			next_bus.rdata = rd(cfg, s_axi_araddr_i[ADDR_W-1:2]);
			next_bus.rresp = hit(s_axi_araddr_i[ADDR_W-1:2]) ? afe_cfg_pkg::RESP_OKAY : afe_cfg_pkg::RESP_SLVERR;
		end
		next_bus.arready = ~next_bus.rvalid;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			bus <= '0;
		end else begin
			bus <= next_bus;
		end
	end

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	always_comb begin
		next_cfg = cfg;
		// Masked merge keeps reserved bits at zero whatever is written
		if (wr_do && wr_en) begin
			if (wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_PIN))
				next_cfg.pin = upd(cfg.pin, wr_data, afe_cfg_pkg::MASK_PIN);
			if (wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_GSW))
				next_cfg.gsw = upd(cfg.gsw, wr_data, afe_cfg_pkg::MASK_GSW);
			if (wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_GAMP))
				next_cfg.gamp = upd(cfg.gamp, wr_data, afe_cfg_pkg::MASK_GAMP);
			if (wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_LED))
				next_cfg.led = upd(cfg.led, wr_data, afe_cfg_pkg::MASK_LED);
			if (wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_PHO))
				next_cfg.pho = upd(cfg.pho, wr_data, afe_cfg_pkg::MASK_PHO);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cfg <= {5{afe_cfg_pkg::RESET_VAL}};
		end else begin
			cfg <= next_cfg;
		end
	end

	// ----------------------------------------
	// Pin synchronisers and decoded controls
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
		logic gpio_out;
		logic gpio_oe;
		logic led_a;
		logic led_b;
		logic buf_on;
		logic [2:0] route;
	} ctl_t;

	ctl_t ctl;
	ctl_t next_ctl;
	logic [2:0] fn;
	logic [1:0] sel;

	assign fn = cfg.pin[afe_cfg_pkg::FN_LSB +: 3];
	assign sel = cfg.pin[afe_cfg_pkg::SEL_LSB +: 2];

	always_comb begin
		next_ctl = ctl;
		next_ctl.meta = {gpio_i, led_b_enable_input_i, led_a_enable_input_i};
		next_ctl.sync = ctl.meta;
		// Pin is an input in the LED modes, driven only for the error flag
		next_ctl.gpio_oe = fn == afe_cfg_pkg::FN_ERR_OUT;
		next_ctl.gpio_out = (fn == afe_cfg_pkg::FN_ERR_OUT) & unmasked_error_i;
		next_ctl.led_a = ctl.sync[0] | ((fn == afe_cfg_pkg::FN_LED_A) & ctl.sync[2]);
		next_ctl.led_b = ctl.sync[1] | ((fn == afe_cfg_pkg::FN_LED_B) & ctl.sync[2]);
		next_ctl.buf_on = ~cfg.pin[afe_cfg_pkg::BYP_BIT] & (sel != 2'h0);
		for (int i = 0; i < 3; i++) begin
			next_ctl.route[i] = sel == 2'(i + 1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctl <= '0;
		end else begin
			ctl <= next_ctl;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready_o = bus.awready;
	assign s_axi_wready_o = bus.wready;
	assign s_axi_bvalid_o = bus.bvalid;
	assign s_axi_bresp_o = bus.bresp;
	assign s_axi_arready_o = bus.arready;
	assign s_axi_rvalid_o = bus.rvalid;
	assign s_axi_rresp_o = bus.rresp;
	assign s_axi_rdata_o = {24'h000000, bus.rdata};
	assign gpio_o = ctl.gpio_out;
	assign gpio_oe_o = ctl.gpio_oe;
	assign led_a_drive_o = ctl.led_a;
	assign led_b_drive_o = ctl.led_b;
	assign monitor_buffer_on_o = ctl.buf_on;
	assign monitor_buffer_bypass_o = cfg.pin[afe_cfg_pkg::BYP_BIT];
	assign monitor_route_o = ctl.route;
	assign gas_out_resistor_on_o = cfg.gsw[afe_cfg_pkg::RO_BIT];
	assign gas_feedback_resistor_on_o = cfg.gsw[afe_cfg_pkg::RG_BIT];
	assign gas_in_resistor_on_o = cfg.gsw[afe_cfg_pkg::RI_BIT];
	assign gas_ref_switch_on_o = cfg.gsw[afe_cfg_pkg::REFSW_BIT];
	assign ref_300mv_buffer_on_o = cfg.gamp[afe_cfg_pkg::R300_BIT];
	assign gas_ref_level_o = cfg.gamp[afe_cfg_pkg::GREF_LSB +: 2];
	assign gas_feedback_level_o = cfg.gamp[afe_cfg_pkg::GFB_LSB +: 2];
	assign sensor_test_direction_o = cfg.gamp[afe_cfg_pkg::TDIR_BIT];
	assign sensor_test_on_o = cfg.gamp[afe_cfg_pkg::TEN_BIT];
	assign gas_amplifier_on_o = cfg.gamp[afe_cfg_pkg::AMP_BIT];
	// Codes 6 and 7 pass through unchanged; the regulator must not be set there
	assign led_regulator_level_o = cfg.led[afe_cfg_pkg::LDO_LSB +: 3];
	assign led_b_temp_coefficient_o = cfg.pho[afe_cfg_pkg::TCB_LSB +: 2];
	assign led_a_temp_coefficient_o = cfg.pho[afe_cfg_pkg::TCA_LSB +: 2];
	assign photo_reference_select_o = cfg.pho[afe_cfg_pkg::PHOTO_REFERENCE_PIN_BIT];
	assign photo_gain_level_o = cfg.pho[afe_cfg_pkg::PHOTO_GAIN_LEVEL_LSB +: 2];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_BYPASS: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cfg.pin[7] |=> !monitor_buffer_on_o)
		else $error("monitor buffer on while bypassed");
	AST_BUF_ON: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!cfg.pin[7] && sel != 2'h0 |=> monitor_buffer_on_o)
		else $error("monitor buffer off with input selected");
	AST_ROUTE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sel == 2'h3 |=> monitor_route_o == 3'h4 ##0 $onehot0(monitor_route_o))
		else $error("photodiode not routed to monitor");
	AST_PIN_HIZ: assert property (@(posedge clk_i) disable iff (!rstn_i)
		fn == 3'h0 |=> !gpio_oe_o)
		else $error("pin driven in high impedance mode");
	AST_PIN_ERR: assert property (@(posedge clk_i) disable iff (!rstn_i)
		fn == 3'h2 |=> gpio_oe_o && gpio_o == $past(unmasked_error_i))
		else $error("error pin does not follow unmasked error");
	AST_LED_A: assert property (@(posedge clk_i) disable iff (!rstn_i)
		fn == 3'h4 && $past(gpio_i, 2) |=> led_a_drive_o)
		else $error("pin did not enable LED A");
	AST_LED_B: assert property (@(posedge clk_i) disable iff (!rstn_i)
		fn == 3'h5 && $past(gpio_i, 2) |=> led_b_drive_o)
		else $error("pin did not enable LED B");
	AST_RESET: assert property (@(posedge clk_i)
		!rstn_i |=> cfg == '0 && !s_axi_bvalid_o && !s_axi_rvalid_o)
		else $error("registers not zero after reset");
	AST_RSVD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(cfg.pin & ~8'hb7) == 8'h00 && cfg.gsw[3:0] == 4'h0 && (cfg.led & ~8'h0e) == 8'h00 && !cfg.pho[7])
		else $error("reserved bit set");
	// A write lands at the edge that answers it, and the field outputs show it from that same edge
	AST_WRITE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_do && wr_en && wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_GAMP) |=> {ref_300mv_buffer_on_o, gas_ref_level_o,
		gas_feedback_level_o, sensor_test_direction_o, sensor_test_on_o, gas_amplifier_on_o} == $past(wr_data))
		else $error("gas amplifier write not applied");
	AST_WRITE_GSW: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_do && wr_en && wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_GSW) |=> {gas_out_resistor_on_o,
		gas_feedback_resistor_on_o, gas_in_resistor_on_o, gas_ref_switch_on_o} == $past(wr_data[7:4]))
		else $error("gas switch write not applied");
	AST_WRITE_LED: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_do && wr_en && wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_LED) |=> led_regulator_level_o == $past(wr_data[3:1]))
		else $error("LED regulator write not applied");
	AST_WRITE_PHO: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_do && wr_en && wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_PHO) |=> {led_b_temp_coefficient_o,
		led_a_temp_coefficient_o, photo_reference_select_o, photo_gain_level_o} == $past(wr_data[6:0]))
		else $error("photo channel write not applied");
	AST_WRITE_PIN: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_do && wr_en && wr_idx == (ADDR_W-2)'(afe_cfg_pkg::IDX_PIN) |=> monitor_buffer_bypass_o == $past(wr_data[7]))
		else $error("bypass write not applied");
	AST_ROUTE_NONE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sel == 2'h0 |=> monitor_route_o == 3'h0)
		else $error("monitor routed with no input selected");
	AST_ROUTE_GAS: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sel == 2'h1 |=> monitor_route_o == 3'h1)
		else $error("gas amplifier output not routed to monitor");
	AST_ROUTE_PHOTO: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sel == 2'h2 |=> monitor_route_o == 3'h2)
		else $error("photo output not routed to monitor");
	AST_PIN_IDLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		fn != afe_cfg_pkg::FN_ERR_OUT |=> !gpio_oe_o && !gpio_o)
		else $error("pin driven outside error output mode");
	AST_LED_A_DED: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(rstn_i, 2) && $past(rstn_i) && $past(led_a_enable_input_i, 2) |=> led_a_drive_o)
		else $error("dedicated input did not enable LED A");
	AST_LED_B_DED: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(rstn_i, 2) && $past(rstn_i) && $past(led_b_enable_input_i, 2) |=> led_b_drive_o)
		else $error("dedicated input did not enable LED B");
	AST_LED_A_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!$past(led_a_enable_input_i, 2) && !$past(gpio_i, 2) |=> !led_a_drive_o)
		else $error("LED A enabled with no request");
	AST_LED_B_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!$past(led_b_enable_input_i, 2) && !$past(gpio_i, 2) |=> !led_b_drive_o)
		else $error("LED B enabled with no request");
	AST_RESET_CTL: assert property (@(posedge clk_i)
		!rstn_i |=> !gpio_oe_o && !led_a_drive_o && !led_b_drive_o && !monitor_buffer_on_o && monitor_route_o == 3'h0)
		else $error("decoded controls not idle after reset");
	AST_BRESP_DUE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_do |=> s_axi_bvalid_o)
		else $error("write response missing");
	AST_BVALID_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped before taken");
	AST_RVALID_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("read answer dropped before taken");
	AST_WR_BLOCKED: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write accepted while response pending");
	AST_RD_BLOCKED: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read accepted while answer pending");
	AST_RD_ZERO_WAIT: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && s_axi_rdata_o[31:8] == 24'h000000)
		else $error("read answer late or wide");
endmodule : afe_config_register_bank

// file: verification/tb_top.sv
// Self-checking testbench for the analog front end configuration register bank
`timescale 1ns/10ps
module tb_top;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic err = 1'b0, gin = 1'b0, lea = 1'b0, leb = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, gout, goe, lda, ldb, mon_on, mon_byp;
	logic g_ro, g_rg, g_ri, g_rs, r300, tdir, ten, amp, psel;
	logic [1:0] bresp, rresp, gref, gfb, tcb, tca, photo_gain_level;
	logic [2:0] route, ldo;
	logic [31:0] rdata, rs = 32'h0000004f;
	logic [31:0] ctl_got;
	int failures = 0, comparisons = 0;
	logic [7:0] mdl [0:31];
	logic [4:0] regs [5] = '{afe_cfg_pkg::IDX_PIN, afe_cfg_pkg::IDX_GSW, afe_cfg_pkg::IDX_GAMP,
		afe_cfg_pkg::IDX_LED, afe_cfg_pkg::IDX_PHO};
	logic [2:0] fns [4] = '{afe_cfg_pkg::FN_HIZ, afe_cfg_pkg::FN_ERR_OUT, afe_cfg_pkg::FN_LED_A, afe_cfg_pkg::FN_LED_B};
	logic [7:0] pats [4] = '{8'hff, 8'h00, 8'h55, 8'haa};

	assign ctl_got = {5'h00, mon_byp, mon_on, route, g_ro, g_rg, g_ri, g_rs, r300, gref, gfb, tdir, ten, amp, ldo,
		tcb, tca, psel, photo_gain_level};

	afe_config_register_bank dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.unmasked_error_i(err), .gpio_i(gin), .gpio_o(gout), .gpio_oe_o(goe), .led_a_enable_input_i(lea),
		.led_b_enable_input_i(leb), .led_a_drive_o(lda), .led_b_drive_o(ldb), .monitor_buffer_on_o(mon_on),
		.monitor_buffer_bypass_o(mon_byp), .monitor_route_o(route), .gas_out_resistor_on_o(g_ro),
		.gas_feedback_resistor_on_o(g_rg), .gas_in_resistor_on_o(g_ri), .gas_ref_switch_on_o(g_rs),
		.ref_300mv_buffer_on_o(r300), .gas_ref_level_o(gref), .gas_feedback_level_o(gfb),
		.sensor_test_direction_o(tdir), .sensor_test_on_o(ten), .gas_amplifier_on_o(amp),
		.led_regulator_level_o(ldo), .led_b_temp_coefficient_o(tcb), .led_a_temp_coefficient_o(tca),
		.photo_reference_select_o(psel), .photo_gain_level_o(photo_gain_level));

	always #2 clk_i = ~clk_i;

	// ----------------------------------------
	// Expectations
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd

	function automatic logic [7:0] mask_of(input logic [4:0] idx);
		case (idx)
			afe_cfg_pkg::IDX_PIN: return afe_cfg_pkg::MASK_PIN;
			afe_cfg_pkg::IDX_GSW: return afe_cfg_pkg::MASK_GSW;
			afe_cfg_pkg::IDX_GAMP: return afe_cfg_pkg::MASK_GAMP;
			afe_cfg_pkg::IDX_LED: return afe_cfg_pkg::MASK_LED;
			afe_cfg_pkg::IDX_PHO: return afe_cfg_pkg::MASK_PHO;
			default: return 8'h00;
		endcase
	endfunction : mask_of

	function automatic logic [31:0] exp_ctl();
		logic [7:0] p;
		logic [2:0] rt;
		p = mdl[afe_cfg_pkg::IDX_PIN];
		rt = (p[5:4] == 2'h1) ? 3'h1 : (p[5:4] == 2'h2) ? 3'h2 : (p[5:4] == 2'h3) ? 3'h4 : 3'h0;
		return {5'h00, p[7], !p[7] && (p[5:4] != 2'h0), rt, mdl[afe_cfg_pkg::IDX_GSW][7:4],
			mdl[afe_cfg_pkg::IDX_GAMP], mdl[afe_cfg_pkg::IDX_LED][3:1], mdl[afe_cfg_pkg::IDX_PHO][6:0]};
	endfunction : exp_ctl

	function automatic logic [3:0] exp_pin();
		logic [2:0] fn;
		fn = mdl[afe_cfg_pkg::IDX_PIN][2:0];
		return {fn == 3'h2, (fn == 3'h2) & err, lea | ((fn == 3'h4) & gin), leb | ((fn == 3'h5) & gin)};
	endfunction : exp_pin

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	task automatic hung();
		failures++;
		$display("Error at %0t: got %h expected %h", $time, 32'h0, 32'h1);
		conclude();
	endtask : hung

	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : settle

	task automatic wr_reg(input logic [4:0] idx, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] r;
		logic [1:0] er;
		int n;
		if (idx == afe_cfg_pkg::IDX_PIN) d[2:0] = fns[d[1:0]];
		er = (mask_of(idx) != 8'h00) ? afe_cfg_pkg::RESP_OKAY : afe_cfg_pkg::RESP_SLVERR;
		@(posedge clk_i);
		awaddr <= {1'b0, idx, 2'b00};
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 100) hung();
		r = bresp;
		bready <= 1'b0;
		chk({30'h0, r}, {30'h0, er});
		if (s[0] && mask_of(idx) != 8'h00) mdl[idx] = d[7:0] & mask_of(idx);
	endtask : wr_reg

	task automatic rd_chk(input logic [4:0] idx);
		logic [1:0] er;
		int n;
		er = (mask_of(idx) != 8'h00) ? afe_cfg_pkg::RESP_OKAY : afe_cfg_pkg::RESP_SLVERR;
		@(posedge clk_i);
		araddr <= {1'b0, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 100) hung();
		chk(rdata, {24'h0, mdl[idx]});
		chk({30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
	endtask : rd_chk

	task automatic do_reset();
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		foreach (mdl[i]) mdl[i] = afe_cfg_pkg::RESET_VAL;
	endtask : do_reset

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] v;
		logic [31:0] e;
		foreach (mdl[i]) mdl[i] = afe_cfg_pkg::RESET_VAL;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (int k = 0; k < 5; k++) rd_chk(regs[k]);
		settle(1);
		chk(ctl_got, exp_ctl());
		$display("Test reset values done");
		for (int k = 0; k < 5; k++) begin
			for (int p = 0; p < 4; p++) begin
				v = rnd();
				wr_reg(regs[k], {v[31:8], pats[p]}, 4'hf);
				rd_chk(regs[k]);
				settle(3);
				chk(ctl_got, exp_ctl());
			end
		end
		for (int c = 0; c < 8; c++) begin
			wr_reg(afe_cfg_pkg::IDX_LED, {28'h0, c[2:0], 1'b1}, 4'h1);
			settle(3);
			chk({29'h0, ldo}, {29'h0, mdl[afe_cfg_pkg::IDX_LED][3:1]});
		end
		$display("Test field patterns done");
		for (int i = 0; i < 40; i++) begin
			v = rnd();
			wr_reg(regs[v[2:0] % 5], rnd(), v[7:4]);
			rd_chk(regs[v[2:0] % 5]);
			settle(3);
			chk(ctl_got, exp_ctl());
		end
		$display("Test random access done");
		wr_reg(5'h0e, 32'hffffffff, 4'hf);
		wr_reg(5'h11, 32'hffffffff, 4'hf);
		for (int k = 0; k < 5; k++) rd_chk(regs[k]);
		rd_chk(5'h0e);
		rd_chk(5'h11);
		$display("Test unmapped access done");
		for (int i = 0; i < 32; i++) begin
			v = rnd();
			@(posedge clk_i);
			err <= v[8];
			gin <= v[9];
			lea <= v[10];
			leb <= v[11];
			wr_reg(afe_cfg_pkg::IDX_PIN, {24'h0, v[12], 1'b0, i[1:0], 2'b00, i[3:2]}, 4'h1);
			settle(6);
			chk({28'h0, goe, gout, lda, ldb}, {28'h0, exp_pin()});
			e = exp_ctl();
			chk({ctl_got[31:22], 22'h0}, {e[31:22], 22'h0});
		end
		$display("Test pin modes done");
		do_reset();
		for (int k = 0; k < 5; k++) rd_chk(regs[k]);
		settle(1);
		chk(ctl_got, exp_ctl());
		$display("Test second reset done");
		conclude();
	end

	initial begin
		#200000;
		hung();
	end
endmodule : tb_top
